// file: design/swk_sleep_ctrl.sv
// Sleep controller with wake-on-interrupt, watchdog and status bits
`timescale 1ns/1ns
module swk_sleep_ctrl
   import swk_pkg::*;
#(
   parameter int NSRC = SWK_NSRC,
   parameter int STARTUP = SWK_OSC_START_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NSRC-1:0] irq_src,
   output logic core_halted,
   output logic vector_req,
   output logic watchdog_expiry_flag,
   output logic powerdown_status
);
   // ==========================
   // Bus decode
   swk_req_s req;
   logic wr;
   logic [NSRC-1:0] src_s1_q, src_s2_q;
   logic [NSRC-1:0] irq_en_q, irq_flag_q;
   logic global_irq_enable_q;
   swk_osc_e osc_mode_q;
   logic [SWK_WDOG_W-1:0] watchdog_timer_q;
   logic [SWK_POST_W-1:0] post_q;
   logic nop_q, woke_q;
   swk_state_e state_q;
   logic wake_cond, sleep_cmd, clrwd_cmd, st_done, st_start, no_delay;

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata,
                  access: psel & penable};
   assign wr = req.access & req.write;
   assign sleep_cmd = wr && req.addr == SWK_CMD_OFF
                      && req.wdata[SWK_CMD_SLEEP];
   assign clrwd_cmd = wr && req.addr == SWK_CMD_OFF
                      && req.wdata[SWK_CMD_CLRWD];
   // Wake test ignores the global enable
   assign wake_cond = |(irq_en_q & irq_flag_q);
   assign no_delay = osc_mode_q == SWK_OSC_RCAP
                     || osc_mode_q == SWK_OSC_EXTCLK;
   assign st_start = state_q == SWK_SLEEP && wake_cond && !no_delay;

   // ==========================
   // Source synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_s1_q <= '0;
         src_s2_q <= '0;
      end else begin
         src_s1_q <= irq_src;
         src_s2_q <= src_s1_q;
      end
   end

   // ==========================
   // Configuration and enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable_q <= 1'b0;
         osc_mode_q <= SWK_OSC_XT;
         irq_en_q <= '0;
      end else if (wr && req.addr == SWK_CTRL_OFF) begin
         global_irq_enable_q <= req.wdata[SWK_CTRL_GLB_EN];
         osc_mode_q <= swk_osc_e'(req.wdata[SWK_CTRL_MODE_LO +: 2]);
      end else if (wr && req.addr == SWK_IRQ_OFF) begin
         irq_en_q <= req.wdata[SWK_IRQ_EN_LO +: NSRC];
      end
   end

   // Flags: set wins over software clear (write one to clear)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_q <= '0;
      end else begin
         irq_flag_q <= (irq_flag_q
            & ~((wr && req.addr == SWK_IRQ_OFF) ? req.wdata[NSRC-1:0] : '0))
            | src_s2_q;
      end
   end

   // ==========================
   // Sleep sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SWK_RUN;
      end else begin
         unique case (state_q)
            SWK_RUN: begin
               if (sleep_cmd) begin
                  state_q <= SWK_EXEC;
               end
            end
            SWK_EXEC: begin
               // Sleep completes as a no-operation or enters low power
               if (nop_q) begin
                  state_q <= SWK_RUN;
               end else begin
                  state_q <= SWK_SLEEP;
               end
            end
            SWK_SLEEP: begin
               if (wake_cond) begin
                  state_q <= no_delay ? SWK_RUN : SWK_START;
               end
            end
            SWK_START: begin
               if (st_done) begin
                  state_q <= SWK_RUN;
               end
            end
         endcase
      end
   end

   // Wake condition seen as the instruction is issued makes it a no-op
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nop_q <= 1'b0;
         woke_q <= 1'b0;
      end else begin
         if (sleep_cmd && state_q == SWK_RUN) begin
            nop_q <= wake_cond;
            woke_q <= 1'b0;
         end
         if (state_q == SWK_SLEEP && wake_cond) begin
            woke_q <= 1'b1;
         end
      end
   end

   // ==========================
   // Watchdog, postscaler and status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_timer_q <= '0;
         post_q <= '0;
      end else if (clrwd_cmd || (state_q == SWK_EXEC && !nop_q)) begin
         watchdog_timer_q <= '0;
         post_q <= '0;
      end else if (state_q == SWK_RUN || state_q == SWK_SLEEP) begin
         watchdog_timer_q <= watchdog_timer_q + 1'b1;
         if (&watchdog_timer_q) begin
            post_q <= post_q + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_expiry_flag <= 1'b1;
         powerdown_status <= 1'b1;
      end else if (state_q == SWK_EXEC && !nop_q) begin
         watchdog_expiry_flag <= 1'b1;
         powerdown_status <= 1'b0;
      end else if (clrwd_cmd) begin
         watchdog_expiry_flag <= 1'b1;
         powerdown_status <= 1'b1;
      end
      // No-op sleep leaves both bits untouched
   end

   swk_startup_timer #(
      .PERIODS(STARTUP)
   ) u_startup (
      .pclk(pclk),
      .presetn(presetn),
      .start(st_start),
      .done(st_done)
   );

   // ==========================
   // Outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_halted <= 1'b0;
         vector_req <= 1'b0;
      end else begin
         core_halted <= state_q == SWK_SLEEP || state_q == SWK_START;
         // Only vector with global enable set; otherwise resume inline
         vector_req <= global_irq_enable_q && wake_cond;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               SWK_CTRL_OFF: prdata <= {29'h0000_0000, osc_mode_q,
                                        global_irq_enable_q};
               SWK_IRQ_OFF: prdata <= 32'({irq_en_q, irq_flag_q});
               SWK_STAT_OFF: prdata <= 32'({woke_q, nop_q,
                  state_q == SWK_START, state_q == SWK_SLEEP,
                  watchdog_expiry_flag, powerdown_status});
               SWK_WDOG_OFF: prdata <= 32'({post_q, watchdog_timer_q});
               SWK_CMD_OFF: prdata <= '0;
               default: pslverr <= 1'b0;
            endcase
         end
         if (psel && !penable && !(paddr inside {SWK_CTRL_OFF, SWK_IRQ_OFF,
             SWK_STAT_OFF, SWK_CMD_OFF, SWK_WDOG_OFF})) begin
            pslverr <= 1'b1;
         end
      end
   end
endmodule

// file: inc/swk_pkg.sv
// Package for the sleep and wake-on-interrupt controller
package swk_pkg;
   // ==========================
   // Register map (byte addresses)
   localparam logic [11:0] SWK_CTRL_OFF = 12'h000;
   localparam logic [11:0] SWK_IRQ_OFF = 12'h004;
   localparam logic [11:0] SWK_STAT_OFF = 12'h008;
   localparam logic [11:0] SWK_CMD_OFF = 12'h00C;
   localparam logic [11:0] SWK_WDOG_OFF = 12'h010;
   // ==========================
   // Control field positions
   localparam int SWK_CTRL_GLB_EN = 0;
   localparam int SWK_CTRL_MODE_LO = 1;
   // Irq register: enables in [15:8], flags in [7:0]
   localparam int SWK_IRQ_EN_LO = 8;
   // Status field positions
   localparam int SWK_STAT_PWRDN = 0;
   localparam int SWK_STAT_EXPIRY = 1;
   localparam int SWK_STAT_SLEEP = 2;
   localparam int SWK_STAT_START = 3;
   localparam int SWK_STAT_NOP = 4;
   localparam int SWK_STAT_WOKE = 5;
   // Command bits
   localparam int SWK_CMD_SLEEP = 0;
   localparam int SWK_CMD_CLRWD = 1;
   // ==========================
   // Timing and sizes
   localparam int SWK_OSC_START_PERIODS = 1024;
   localparam int SWK_NSRC = 8;
   localparam int SWK_WDOG_W = 16;
   localparam int SWK_POST_W = 8;
   // ==========================
   typedef enum logic [1:0] {
      SWK_OSC_XT, SWK_OSC_HS, SWK_OSC_RCAP, SWK_OSC_EXTCLK
   } swk_osc_e;
   typedef enum {SWK_RUN, SWK_EXEC, SWK_SLEEP, SWK_START} swk_state_e;
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
      logic access;
   } swk_req_s;
endpackage

// file: design/swk_startup_timer.sv
// Oscillator start-up delay counter
`timescale 1ns/1ns
module swk_startup_timer
   import swk_pkg::*;
#(
   parameter int PERIODS = SWK_OSC_START_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   output logic done
);
   localparam int CW = $clog2(PERIODS + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);
   logic [CW-1:0] cnt_q;
   logic run_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            // Start edge counts as the first period
            cnt_q <= CW'(1);
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q == LAST) begin
               run_q <= 1'b0;
               done <= 1'b1;
            end
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule

// file: sim/swk_sleep_ctrl_asserts.sv
// Port-level checker for the sleep controller
`timescale 1ns/1ns
module swk_sleep_ctrl_asserts
   import swk_pkg::*;
#(
   parameter int NSRC = SWK_NSRC,
   parameter int STARTUP = SWK_OSC_START_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NSRC-1:0] irq_src,
   input wire logic core_halted,
   input wire logic vector_req,
   input wire logic watchdog_expiry_flag,
   input wire logic powerdown_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================
   // Bus answer
   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("pready missing after setup");
   property p_ready_in_access;
      pready |-> psel && penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("pready outside access");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("pready longer than one cycle");
   property p_unmapped;
      psel && !penable && paddr > SWK_WDOG_OFF |=> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("no error on unmapped address");
   property p_mapped;
      psel && !penable && paddr <= SWK_WDOG_OFF && paddr[1:0] == 2'h0
         |=> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped)
      else $error("error on mapped address");
   // ==========================
   // Status bits
   property p_expiry_kept;
      !$fell(watchdog_expiry_flag);
   endproperty
   a_expiry_kept: assert property (p_expiry_kept)
      else $error("expiry flag cleared");
   property p_pd_fall;
      $fell(powerdown_status) |-> watchdog_expiry_flag ##[1:2] core_halted;
   endproperty
   a_pd_fall: assert property (p_pd_fall)
      else $error("real sleep without expiry or halt");
   property p_pd_rise;
      $rose(powerdown_status) |-> watchdog_expiry_flag && !core_halted;
   endproperty
   a_pd_rise: assert property (p_pd_rise)
      else $error("powerdown set in wrong state");
   property p_halt_pd;
      $rose(core_halted) |-> !powerdown_status;
   endproperty
   a_halt_pd: assert property (p_halt_pd)
      else $error("halted while powerdown set");
endmodule

bind swk_sleep_ctrl swk_sleep_ctrl_asserts #(.NSRC(NSRC), .STARTUP(STARTUP))
   u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq_src(irq_src),
   .core_halted(core_halted), .vector_req(vector_req),
   .watchdog_expiry_flag(watchdog_expiry_flag),
   .powerdown_status(powerdown_status));

// file: sim/swk_sleep_ctrl_tb.sv
// Self-checking bench for the sleep controller
`timescale 1ns/1ns
module swk_sleep_ctrl_tb
   import swk_pkg::*;
   ;
   localparam int ST = 16;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0] irq_src = 8'h00;
   logic [7:0] lf = 8'h5E;
   logic [31:0] prdata, rdat, w1;
   logic pready, pslverr, core_halted, vector_req, rerr;
   logic watchdog_expiry_flag, powerdown_status;
   int errors = 0;
   int checked = 0;
   int cnt, s;
   swk_sleep_ctrl #(.NSRC(8), .STARTUP(ST)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_src(irq_src), .core_halted(core_halted),
      .vector_req(vector_req), .watchdog_expiry_flag(watchdog_expiry_flag),
      .powerdown_status(powerdown_status));
   initial forever #50 pclk = ~pclk;
   // ==========================
   // Helpers
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      bit ok;
      ok = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            ok = 1;
            rdat = prdata;
            rerr = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok) begin
         errors++;
         final_report();
      end
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic slow_osc(input int m);
      return !(m == SWK_OSC_RCAP || m == SWK_OSC_EXTCLK);
   endfunction
   // Two sync flops, flag, sequencer, start-up wait, halt output
   function automatic int wake_lat(input int m);
      return slow_osc(m) ? ST + 6 : 6;
   endfunction
   // ==========================
   // Sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(watchdog_expiry_flag, 1'b1);
      chk(powerdown_status, 1'b1);
      apb(1'b0, SWK_STAT_OFF, 32'h0000_0000);
      chk(rdat, 32'h0000_0003);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk(rerr, 1'b1);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         @(posedge pclk);
         irq_src <= 8'h00;
         lf = lfsr(lf);
         s = lf[2:0];
         apb(1'b1, SWK_CTRL_OFF, 32'(m) << 1);
         apb(1'b1, SWK_IRQ_OFF, {16'h0000, lf, 8'hFF} | (32'h1 << (s + 8)));
         apb(1'b1, SWK_CMD_OFF, 32'h0000_0002);
         repeat (30) @(posedge pclk);
         apb(1'b0, SWK_WDOG_OFF, 32'h0000_0000);
         w1 = rdat;
         apb(1'b1, SWK_CMD_OFF, 32'h0000_0001);
         repeat (4) @(negedge pclk);
         chk(core_halted, 1'b1);
         chk(powerdown_status, 1'b0);
         chk(watchdog_expiry_flag, 1'b1);
         apb(1'b0, SWK_WDOG_OFF, 32'h0000_0000);
         chk(rdat[15:0] < w1[15:0] || rdat[23:16] < w1[23:16], 1'b1);
         @(posedge pclk);
         irq_src <= 8'h01 << s;
         cnt = 0;
         while (core_halted !== 1'b0 && cnt < 200) begin
            @(negedge pclk);
            cnt++;
         end
         if (cnt >= 200) begin
            errors++;
            final_report();
         end
         chk(cnt, wake_lat(m));
         chk(powerdown_status, 1'b0);
         chk(vector_req, 1'b0);
         apb(1'b0, SWK_STAT_OFF, 32'h0000_0000);
         chk(rdat[SWK_STAT_WOKE], 1'b1);
         chk(rdat[SWK_STAT_NOP], 1'b0);
         apb(1'b0, SWK_IRQ_OFF, 32'h0000_0000);
         chk(rdat[s], 1'b1);
         apb(1'b1, SWK_CMD_OFF, 32'h0000_0002);
         @(negedge pclk);
         chk(powerdown_status, 1'b1);
         $display("test sleep mode %0d done", m);
      end
      // Flag still pending: this sleep must do nothing
      apb(1'b0, SWK_WDOG_OFF, 32'h0000_0000);
      w1 = rdat;
      apb(1'b1, SWK_CMD_OFF, 32'h0000_0001);
      repeat (4) @(negedge pclk);
      chk(core_halted, 1'b0);
      chk(powerdown_status, 1'b1);
      apb(1'b0, SWK_STAT_OFF, 32'h0000_0000);
      chk(rdat[SWK_STAT_NOP], 1'b1);
      apb(1'b0, SWK_WDOG_OFF, 32'h0000_0000);
      chk(rdat[15:0] > w1[15:0] || rdat[23:16] > w1[23:16], 1'b1);
      apb(1'b1, SWK_CTRL_OFF, 32'h0000_0001);
      repeat (2) @(negedge pclk);
      chk(vector_req, 1'b1);
      $display("test nop sleep done");
      final_report();
   end
endmodule
